// [link_status_defines.vh]
// Constants for the repeater link status indicator.
`ifndef LINK_STATUS_DEFINES_VH
`define LINK_STATUS_DEFINES_VH
`define CLK_FREQ_HZ 125000000
`define RX_TIMEOUT_MS 500
`define RX_TIMEOUT_CYCLES ((`CLK_FREQ_HZ / 1000) * `RX_TIMEOUT_MS)
`define NUM_PORTS 3
`define LED_OFF 2'h0
`define LED_GREEN 2'h1
`define LED_ORANGE 2'h2
`define LED_RED 2'h2
`define ERR_HOLD_CYCLES 32'h007FFFFF
`endif

// [link_status_indicator.v]
// Port and system status indicators with fault relay for a three-port repeater.
// Function
// - System indicator green when every port receives and supply is adequate.
// - System indicator red when any port saw no data for 500 ms.
// - Supply low keeps system indicator dark and opens the fault relay.
// - Port indicator off after 500 ms without received data.
// - Port indicator green while receiving with no error detected.
// - Port indicator orange on echo error of a receiving port.
// - Port indicator orange on jabber or fragment on a receiving port.
// - Relay opens on any 500 ms silence, closed only when all receive.
`timescale 1ns/1ps
`include "link_status_defines.vh"

// ----------------------------------------
// Link status indicator
// ----------------------------------------
// Each port watches its receive line for activity, errors and silence.
// The three port states and the supply supervision are then folded into
// one system indicator and one fault relay output.
// Every event and supply input is asynchronous, so each passes two flip-flops
// before any logic reads it.
// All outputs come straight from registers, so the lamp and relay drivers
// never see a combinational glitch.
module link_status_indicator #(
    parameter NUM_PORTS = `NUM_PORTS,
    parameter [31:0] TIMEOUT_CYCLES = `RX_TIMEOUT_CYCLES,
    parameter [31:0] ERR_HOLD = `ERR_HOLD_CYCLES
) (
    // Clock and reset.
    input wire clk,
    input wire rst_n,
    // Per-port events from the receive paths, asynchronous to clk.
    input wire [NUM_PORTS-1:0] rx_activity,
    input wire [NUM_PORTS-1:0] echo_error,
    input wire [NUM_PORTS-1:0] malformed_packet,
    // Analog supervision, asynchronous.
    input wire supply_low,
    // Indicators and relay.
    output reg [2*NUM_PORTS-1:0] port_led,
    output reg [1:0] system_led,
    output reg relay_closed
);

    // ----------------------------------------
    // Local constants
    // ----------------------------------------
    // Width of the packed synchroniser word: three events per port and supply low.
    localparam SYNC_W = 3 * NUM_PORTS + 1;

    // ----------------------------------------
    // Colour selection
    // ----------------------------------------
    // Picks a port colour from its loss and error state.
    // Loss wins over errors, because an orange lamp on a silent port would
    // hide a broken link behind a mere error warning.
    function [1:0] port_colour;
        input lost_in;
        input err_in;
        begin
            if (lost_in) begin
                port_colour = `LED_OFF;
            end else if (err_in) begin
                port_colour = `LED_ORANGE;
            end else begin
                port_colour = `LED_GREEN;
            end
        end
    endfunction

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    reg [SYNC_W-1:0] sync1;
    reg [SYNC_W-1:0] sync2;
    reg [NUM_PORTS-1:0] act_prev;

    // First stage catches the asynchronous levels and may go metastable.
    always @(posedge clk) begin
        if (!rst_n) begin
            sync1 <= {SYNC_W{1'b0}};
        end else begin
            sync1 <= {supply_low, malformed_packet, echo_error, rx_activity};
        end
    end

    // Second stage is the only reader of the first stage.
    always @(posedge clk) begin
        if (!rst_n) begin
            sync2 <= {SYNC_W{1'b0}};
        end else begin
            sync2 <= sync1;
        end
    end

    // History of the settled activity lines for edge detection.
    // It resets to the idle level of the lines, so no false edge follows reset.
    always @(posedge clk) begin
        if (!rst_n) begin
            act_prev <= {NUM_PORTS{1'b0}};
        end else begin
            act_prev <= sync2[NUM_PORTS-1:0];
        end
    end

    // Settled fields of the synchroniser word.
    wire [NUM_PORTS-1:0] act_s;
    wire [NUM_PORTS-1:0] echo_s;
    wire [NUM_PORTS-1:0] mal_s;
    wire low_s;

    assign act_s = sync2[NUM_PORTS-1:0];
    assign echo_s = sync2[2*NUM_PORTS-1:NUM_PORTS];
    assign mal_s = sync2[3*NUM_PORTS-1:2*NUM_PORTS];
    assign low_s = sync2[3*NUM_PORTS];

    // ----------------------------------------
    // Per-port timers and error stretchers
    // ----------------------------------------
    wire [NUM_PORTS-1:0] lost_flag;
    wire [NUM_PORTS-1:0] err_flag;
    wire [2*NUM_PORTS-1:0] next_port_led;

    genvar i;
    generate
        for (i = 0; i < NUM_PORTS; i = i + 1) begin : g_port
            reg [31:0] idle_cnt;
            reg [31:0] next_idle_cnt;
            reg lost;
            reg next_lost;
            reg [31:0] err_cnt;
            reg [31:0] next_err_cnt;
            wire edge_seen;
            wire err_now;

            // Any change of the settled line, rising or falling, counts as activity.
            assign edge_seen = act_s[i] ^ act_prev[i];
            assign err_now = echo_s[i] | mal_s[i];

            // Inactivity timer restarts on any activity edge.
            // When it reaches the timeout it holds and flags the port as lost.
            always @* begin
                next_idle_cnt = idle_cnt;
                next_lost = lost;
                if (edge_seen) begin
                    next_idle_cnt = 32'h00000000;
                    next_lost = 1'b0;
                end else if (idle_cnt >= TIMEOUT_CYCLES - 32'h00000001) begin
                    next_lost = 1'b1;
                end else begin
                    next_idle_cnt = idle_cnt + 32'h00000001;
                end
            end

            // Timer registers; a port counts as lost until it is first heard.
            always @(posedge clk) begin
                if (!rst_n) begin
                    idle_cnt <= 32'h00000000;
                    lost <= 1'b1;
                end else begin
                    idle_cnt <= next_idle_cnt;
                    lost <= next_lost;
                end
            end

            // Error stretcher keeps orange visible after a one-cycle error pulse.
            // A new error reloads the hold time, so a burst reads as one long warning.
            always @* begin
                next_err_cnt = err_cnt;
                if (err_now) begin
                    next_err_cnt = ERR_HOLD;
                end else if (err_cnt != 32'h00000000) begin
                    next_err_cnt = err_cnt - 32'h00000001;
                end
            end

            // Stretcher register.
            always @(posedge clk) begin
                if (!rst_n) begin
                    err_cnt <= 32'h00000000;
                end else begin
                    err_cnt <= next_err_cnt;
                end
            end

            // Port state seen by the colour choice and the system logic.
            assign lost_flag[i] = lost;
            assign err_flag[i] = err_now | (err_cnt != 32'h00000000);
            assign next_port_led[2*i+1:2*i] = port_colour(lost, err_flag[i]);
        end
    endgenerate

    // ----------------------------------------
    // System indicator and relay
    // ----------------------------------------
    reg [1:0] next_system_led;
    reg next_relay_closed;

    // Supply low wins over everything; then any lost port gives red and an open relay.
    // The relay closes only when every port is receiving.
    always @* begin
        next_system_led = `LED_OFF;
        next_relay_closed = 1'b0;
        if (low_s) begin
            next_system_led = `LED_OFF;
            next_relay_closed = 1'b0;
        end else if (~|lost_flag) begin
            next_system_led = `LED_GREEN;
            next_relay_closed = 1'b1;
        end else begin
            next_system_led = `LED_RED;
            next_relay_closed = 1'b0;
        end
    end

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    // All lamps dark and the relay open while reset is held.
    always @(posedge clk) begin
        if (!rst_n) begin
            port_led <= {NUM_PORTS{`LED_OFF}};
            system_led <= `LED_OFF;
            relay_closed <= 1'b0;
        end else begin
            port_led <= next_port_led;
            system_led <= next_system_led;
            relay_closed <= next_relay_closed;
        end
    end

endmodule // link_status_indicator

// [lsi_chk.sv]
// Assertion checker for the link status indicator ports.
`timescale 1ns/1ps
module lsi_chk #(parameter [31:0] TIMEOUT_CYCLES = 50) (input wire clk, input wire rst_n,
 input wire [2:0] rx_activity, input wire [2:0] echo_error, input wire [2:0] malformed_packet,
 input wire supply_low, input wire [5:0] port_led, input wire [1:0] system_led, input wire relay_closed);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
wire all_on = |port_led[1:0] & |port_led[3:2] & |port_led[5:4];
reg p;
reg [7:0] q;
// Counts the cycles for which port 0 has not toggled.
always @(posedge clk) begin
    if (!rst_n) begin
        p <= 1'b0;
        q <= 8'h00;
    end else begin
        p <= rx_activity[0];
        q <= (p != rx_activity[0]) ? 8'h00 : q + {7'h00, q != 8'hFF};
    end
end
property p_sup; supply_low [*4] |=> system_led == 2'h0 && !relay_closed; endproperty
a_sup: assert property (p_sup) else $error("dark");
property p_ok; (!supply_low) [*6] |-> relay_closed || system_led == 2'h2; endproperty
a_ok: assert property (p_ok) else $error("state");
property p_grn; system_led == 2'h1 |-> relay_closed; endproperty
a_grn: assert property (p_grn) else $error("green");
property p_red; system_led == 2'h2 |-> !relay_closed; endproperty
a_red: assert property (p_red) else $error("red");
property p_off; {24'h000000, q} > TIMEOUT_CYCLES + 8 |-> port_led[1:0] == 2'h0; endproperty
a_off: assert property (p_off) else $error("off");
property p_srel; {24'h000000, q} > TIMEOUT_CYCLES + 8 |-> !relay_closed; endproperty
a_srel: assert property (p_srel) else $error("relay");
property p_org; port_led[1:0] == 2'h1 ##1 (echo_error[0] | malformed_packet[0]) [*4] |=> port_led[1:0] != 2'h1;
endproperty
a_org: assert property (p_org) else $error("orange");
property p_rp; relay_closed |-> all_on || $past(all_on); endproperty
a_rp: assert property (p_rp) else $error("ports");
endmodule // lsi_chk
bind link_status_indicator lsi_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_lsi_chk (.clk(clk), .rst_n(rst_n),
 .rx_activity(rx_activity), .echo_error(echo_error), .malformed_packet(malformed_packet), .supply_low(supply_low),
 .port_led(port_led), .system_led(system_led), .relay_closed(relay_closed));

// [lsi_seg.sv]
// Field bus segment model that toggles each receive line while its link is up.
`timescale 1ns/1ps
module lsi_seg (input wire clk, input wire [2:0] en, output reg [2:0] rx);
initial rx = 3'h0;
// A silent segment holds its line still, as a broken fibre would.
always @(posedge clk) rx <= rx ^ en;
endmodule // lsi_seg

// [tb.sv]
// Self-checking bench for the link status indicator.
`timescale 1ns/1ps
module tb;
reg clk = 0, rst_n = 0, sup = 0;
reg [2:0] en = 0, ec = 0, mf = 0;
wire [2:0] rx;
wire [5:0] pl;
wire [1:0] sl;
wire rc;
int err_total = 0, n_tests = 0;
always #4 clk = ~clk;
lsi_seg i_lsi_seg (.clk(clk), .en(en), .rx(rx));
link_status_indicator #(.TIMEOUT_CYCLES(50), .ERR_HOLD(8)) i_link_status_indicator (.clk(clk), .rst_n(rst_n),
 .rx_activity(rx), .echo_error(ec), .malformed_packet(mf), .supply_low(sup), .port_led(pl), .system_led(sl),
 .relay_closed(rc));
task w(input int n); repeat (n) @(posedge clk); endtask
task c(input [8:0] e);
    @(negedge clk);
    n_tests++;
    if ({pl, sl, rc} !== e) begin err_total++; $display("[FAIL] %0t got %h", $time, {pl, sl, rc}); end
    @(posedge clk);
endtask
task print_verdict;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
task t_up; w(4); c(9'h004); en <= 3'h7; w(12); c(9'h0AB); $display("up end"); endtask
task t_err; ec <= 3'h3; mf <= 3'h4; w(8); c(9'h153); ec <= 3'h0; mf <= 3'h0; w(4); c(9'h153); w(16); c(9'h0AB);
    $display("err end"); endtask
task t_loss; en <= 3'h6; w(62); c(9'h0A4); en <= 3'h7; w(8); c(9'h0AB); $display("loss end"); endtask
task t_sup; sup <= 1'b1; w(6); c(9'h0A8); sup <= 1'b0; w(6); c(9'h0AB); $display("sup end"); endtask
// Main sequence after five cycles of reset.
initial begin
    w(5);
    rst_n <= 1'b1;
    t_up;
    t_err;
    t_loss;
    t_sup;
    print_verdict;
end
// Watchdog well beyond the expected run length.
initial begin #5000; err_total++; print_verdict; end
endmodule // tb
